// [verilog/gpio_port.sv]
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module gpio_port
(
    input  wire logic                         ref_clk,
    input  wire logic                         nrst,
    input  wire logic [gpio_pkg::ADDR_W-1:0]  addr,
    input  wire logic [gpio_pkg::DATA_W-1:0]  wdata,
    input  wire logic                         wr_stb,
    input  wire logic                         rd_stb,
    output logic      [gpio_pkg::DATA_W-1:0]  rdata,
    input  wire logic [gpio_pkg::NPINS-1:0]   pin_in,
    output logic      [gpio_pkg::NPINS-1:0]   pin_out,
    output logic      [gpio_pkg::NPINS-1:0]   pin_oe_n,
    output logic      [gpio_pkg::NPINS-1:0]   pullup_on,
    input  wire logic                         comparator_digital_output,
    output logic                              timer_zero_clock_input,
    output logic                              ext_edge_irq,
    output logic      [1:0]                   adc_sel_pin01,
    output logic      [1:0]                   cmp_sel_pin01,
    output logic                              adc_vref_sel,
    output logic                              adc_sel_pin2,
    output logic                              wake_up,
    output logic                              irq
);
    import gpio_pkg::*;

    logic [NPINS-1:0] sync1_ff;
    logic [NPINS-1:0] sync2_ff;
    logic [NPINS-1:0] latch_ff;
    logic [NPINS-1:0] dir_ff;
    logic [NPINS-1:0] pu_ff;
    logic [NPINS-1:0] ioc_ff;
    logic             gie_ff;
    logic             pcf_ff;
    logic             gpd_ff;
    logic [6:0]       func_ff;
    logic [NEVT-1:0]  evt_stat_ff;
    logic [NEVT-1:0]  evt_en_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [NPINS-1:0] pin_out_ff;
    logic [NPINS-1:0] oe_n_ff;
    logic [NPINS-1:0] pu_out_ff;
    logic             irq_ff;
    logic             wake_ff;
    logic             t0_ff;
    logic             ext_prev_ff;
    logic             ext_irq_ff;
    logic [1:0]       adc01_ff;
    logic [1:0]       cmp01_ff;
    logic             vref_ff;
    logic             adc2_ff;

    logic [NPINS-1:0] snapshot;
    logic             mismatch;
    logic             port_access;
    wire logic        wr_port  = wr_stb && addr == PORT_DATA_ADDR;
    wire logic        rd_port  = rd_stb && addr == PORT_DATA_ADDR;
    wire logic        wr_irqc  = wr_stb && addr == IRQ_CTRL_ADDR;
    wire logic        wr_opt   = wr_stb && addr == OPTION_ADDR;
    wire logic        wr_dir   = wr_stb && addr == PIN_DIRECTION_ADDR;
    wire logic        wr_pu    = wr_stb && addr == PULLUP_ENABLE_ADDR;
    wire logic        wr_ioc   = wr_stb && addr == CHANGE_IRQ_ADDR;
    wire logic        wr_func  = wr_stb && addr == PIN_FUNC_ADDR;
    wire logic        wr_een   = wr_stb && addr == EVT_ENABLE_ADDR;
    wire logic        wr_eclr  = wr_stb && addr == EVT_CLEAR_ADDR;

    analog_func_type  f0;
    analog_func_type  f1;
    pin2_func_type    f2;
    assign f0 = analog_func_type'(func_ff[F0_LSB +: 2]);
    assign f1 = analog_func_type'(func_ff[F1_LSB +: 2]);
    assign f2 = pin2_func_type'(func_ff[F2_LSB +: 3]);

    assign port_access = wr_port || rd_port;

    change_detect u_change
    (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .pins_sync   (sync2_ff),
        .enable_bits (ioc_ff),
        .port_access (port_access),
        .snapshot    (snapshot),
        .mismatch    (mismatch)
    );

    function automatic logic [DATA_W-1:0] pad6(input logic [NPINS-1:0] v);
        pad6 = {2'b00, v};
    endfunction

    // pins handed to an analog function read as zero
    logic [NPINS-1:0] analog_mask;
    assign analog_mask = {3'b000, f2 == P2_ADC,
                          f1 != AF_DIGITAL, f0 != AF_DIGITAL};
    logic [NPINS-1:0] pin_read;
    assign pin_read = sync2_ff & ~analog_mask;

    logic [NPINS-1:0] dir_eff;
    assign dir_eff = dir_ff | (NPINS'(1) << INPUT_ONLY_PIN);

    // comparator output takes over the pin-two driver
    logic [NPINS-1:0] drive_val;
    assign drive_val = (f2 == P2_CMP_OUT) ?
        {latch_ff[5:3], comparator_digital_output, latch_ff[1:0]} :
        latch_ff;
    logic [NPINS-1:0] oe_n_nxt;
    assign oe_n_nxt = (f2 == P2_CMP_OUT) ?
        (dir_eff & ~(NPINS'(1) << 2)) : dir_eff;

    logic [NPINS-1:0] nxt_pu;
    assign nxt_pu = gpd_ff ? '0 :
        (pu_ff & PULLUP_IMPL_MASK & dir_eff);

    logic [DATA_W-1:0] rd_mux;
    always_comb
    begin
        unique case (addr)
            PORT_DATA_ADDR:     rd_mux = pad6(pin_read);
            IRQ_CTRL_ADDR:      rd_mux = {gie_ff, 6'h00, pcf_ff};
            OPTION_ADDR:        rd_mux = {gpd_ff, 7'h00};
            PIN_DIRECTION_ADDR: rd_mux = pad6(dir_eff);
            PULLUP_ENABLE_ADDR: rd_mux = pad6(pu_ff & PULLUP_IMPL_MASK);
            CHANGE_IRQ_ADDR:    rd_mux = pad6(ioc_ff);
            PIN_FUNC_ADDR:      rd_mux = {1'b0, func_ff};
            EVT_STATUS_ADDR:    rd_mux = {6'h00, evt_stat_ff};
            EVT_ENABLE_ADDR:    rd_mux = {6'h00, evt_en_ff};
            default:            rd_mux = 8'h00;
        endcase
    end

    wire logic ext_pin = sync2_ff[2] && f2 == P2_EXT_IRQ;
    wire logic ext_rise = ext_pin && !ext_prev_ff;
    logic [NEVT-1:0] evt_pulse;
    assign evt_pulse = {ext_rise, mismatch};

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            latch_ff <= PORT_LATCH_RESET;
            dir_ff   <= DIRECTION_RESET;
            pu_ff    <= PULLUP_RESET;
            ioc_ff   <= CHANGE_IRQ_RESET;
            gie_ff   <= 1'b0;
            gpd_ff   <= 1'b1;
            func_ff  <= PIN_FUNC_RESET;
            evt_en_ff <= '0;
        end
        else
        begin
            if (wr_port)   // all six latch bits load from wdata, none from the pins
                latch_ff <= wdata[NPINS-1:0];
            if (wr_dir)
                dir_ff <= wdata[NPINS-1:0];
            if (wr_pu)
                pu_ff <= wdata[NPINS-1:0] & PULLUP_IMPL_MASK;
            if (wr_ioc)
                ioc_ff <= wdata[NPINS-1:0];
            if (wr_irqc)
                gie_ff <= wdata[GIE_BIT];
            if (wr_opt)
                gpd_ff <= wdata[GPD_BIT];
            if (wr_func)
                func_ff <= wdata[6:0];
            if (wr_een)
                evt_en_ff <= wdata[NEVT-1:0];
        end
    end

    // hardware set wins over any software clear
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pcf_ff      <= 1'b0;
            evt_stat_ff <= '0;
        end
        else
        begin
            pcf_ff <= mismatch ||
                (pcf_ff && !(wr_irqc && !wdata[PCF_BIT]));
            evt_stat_ff <= evt_pulse |
                (evt_stat_ff & ~(wr_eclr ? wdata[NEVT-1:0] : '0));
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_ff    <= '0;
            pin_out_ff  <= '0;
            oe_n_ff     <= '1;
            pu_out_ff   <= '0;
            irq_ff      <= 1'b0;
            wake_ff     <= 1'b0;
            t0_ff       <= 1'b0;
            ext_prev_ff <= 1'b0;
            ext_irq_ff  <= 1'b0;
            adc01_ff    <= '0;
            cmp01_ff    <= '0;
            vref_ff     <= 1'b0;
            adc2_ff     <= 1'b0;
        end
        else
        begin
            rdata_ff    <= rd_stb ? rd_mux : '0;
            pin_out_ff  <= drive_val;
            oe_n_ff     <= oe_n_nxt;
            pu_out_ff   <= nxt_pu;
            irq_ff      <= gie_ff &&
                ((pcf_ff && evt_en_ff[EVT_CHANGE]) ||
                 |(evt_stat_ff & evt_en_ff));
            wake_ff     <= pcf_ff;
            t0_ff       <= sync2_ff[2] && f2 == P2_TMR_CLK;
            ext_prev_ff <= ext_pin;
            ext_irq_ff  <= ext_rise;
            adc01_ff    <= {f1 == AF_ADC, f0 == AF_ADC};
            cmp01_ff    <= {f1 == AF_CMP, f0 == AF_CMP};
            vref_ff     <= f1 == AF_VREF;
            adc2_ff     <= f2 == P2_ADC;
        end
    end

    assign rdata                  = rdata_ff;
    assign pin_out                = pin_out_ff;
    assign pin_oe_n               = oe_n_ff;
    assign pullup_on              = pu_out_ff;
    assign irq                    = irq_ff;
    assign wake_up                = wake_ff;
    assign timer_zero_clock_input = t0_ff;
    assign ext_edge_irq           = ext_irq_ff;
    assign adc_sel_pin01          = adc01_ff;
    assign cmp_sel_pin01          = cmp01_ff;
    assign adc_vref_sel           = vref_ff;
    assign adc_sel_pin2           = adc2_ff;

    a_dir_tristate: assert property (@(posedge ref_clk) disable iff (!nrst)
        pin_oe_n[INPUT_ONLY_PIN])
        else $error("input-only pin driven");
    a_dir_readback: assert property (@(posedge ref_clk) disable iff (!nrst)
        rd_stb && addr == PIN_DIRECTION_ADDR |=>
        rdata[7:6] == 2'b00 && rdata[INPUT_ONLY_PIN])
        else $error("direction readback wrong");
    a_pullup_gated: assert property (@(posedge ref_clk) disable iff (!nrst)
        gpd_ff || !dir_eff[0] |=> !pullup_on[0])
        else $error("pull-up on while disabled");
    a_pullup_bit3: assert property (@(posedge ref_clk) disable iff (!nrst)
        !pullup_on[3])
        else $error("pull-up on unimplemented bit");
    a_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        mismatch |=> pcf_ff)
        else $error("change flag not set on mismatch");
    a_irq_global: assert property (@(posedge ref_clk) disable iff (!nrst)
        !gie_ff |=> !irq)
        else $error("irq without global enable");
    a_wake_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
        pcf_ff |=> wake_up)
        else $error("no wake on change flag");
    sequence s_access;
        port_access;
    endsequence
    a_access_ends: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_access ##1 $stable(sync2_ff) |->
        !mismatch && snapshot == sync2_ff)
        else $error("mismatch survives port access");
    a_ioc_reset: assert property (@(posedge ref_clk)
        $rose(nrst) |-> ioc_ff == CHANGE_IRQ_RESET)
        else $error("change enables not clear after reset");
endmodule

// [verilog/gpio_pkg.sv]
package gpio_pkg;
    localparam int          NPINS              = 6;
    localparam int          ADDR_W             = 8;
    localparam int          DATA_W             = 8;
    localparam int          INPUT_ONLY_PIN     = 3;
    localparam logic [7:0]  PORT_DATA_ADDR     = 8'h05;
    localparam logic [7:0]  IRQ_CTRL_ADDR      = 8'h0b;
    localparam logic [7:0]  OPTION_ADDR        = 8'h81;
    localparam logic [7:0]  PIN_DIRECTION_ADDR = 8'h85;
    localparam logic [7:0]  PULLUP_ENABLE_ADDR = 8'h95;
    localparam logic [7:0]  CHANGE_IRQ_ADDR    = 8'h96;
    localparam logic [7:0]  PIN_FUNC_ADDR      = 8'ha0;
    localparam logic [7:0]  EVT_STATUS_ADDR    = 8'ha1;
    localparam logic [7:0]  EVT_ENABLE_ADDR    = 8'ha2;
    localparam logic [7:0]  EVT_CLEAR_ADDR     = 8'ha3;
    localparam logic [5:0]  DIRECTION_RESET    = 6'h3f;
    localparam logic [5:0]  PULLUP_IMPL_MASK   = 6'h37;
    localparam logic [5:0]  PULLUP_RESET       = 6'h37;
    localparam logic [5:0]  CHANGE_IRQ_RESET   = 6'h00;
    localparam logic [5:0]  PORT_LATCH_RESET   = 6'h00;
    localparam logic [6:0]  PIN_FUNC_RESET     = 7'h00;
    // irq control register bit positions
    localparam int          GIE_BIT            = 7;
    localparam int          PCF_BIT            = 0;
    // option register bit position, global pull-up disable
    localparam int          GPD_BIT            = 7;
    // pin function register fields
    localparam int          F0_LSB             = 0;
    localparam int          F1_LSB             = 2;
    localparam int          F2_LSB             = 4;
    localparam int          NEVT               = 2;
    localparam int          EVT_CHANGE         = 0;
    localparam int          EVT_EXT_EDGE       = 1;
    typedef enum logic [1:0] {
        AF_DIGITAL, AF_ADC, AF_CMP, AF_VREF
    } analog_func_type;
    typedef enum logic [2:0] {
        P2_DIGITAL, P2_ADC, P2_TMR_CLK, P2_EXT_IRQ, P2_CMP_OUT
    } pin2_func_type;
endpackage

// [verilog/change_detect.sv]
`timescale 1ns/1ps
module change_detect
(
    input  wire logic                        ref_clk,
    input  wire logic                        nrst,
    input  wire logic [gpio_pkg::NPINS-1:0]  pins_sync,
    input  wire logic [gpio_pkg::NPINS-1:0]  enable_bits,
    input  wire logic                        port_access,
    output logic      [gpio_pkg::NPINS-1:0]  snapshot,
    output logic                             mismatch
);
    import gpio_pkg::*;

    logic [NPINS-1:0] snap_ff;
    logic [NPINS-1:0] diff_bits;

    assign diff_bits = (pins_sync ^ snap_ff) & enable_bits;
    assign mismatch  = |diff_bits;
    assign snapshot  = snap_ff;

    // the cycle after the access shows no mismatch if the pins hold; a change landing in the
    // access cycle still mismatches the old snapshot in that cycle
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            snap_ff <= '0;
        else if (port_access)
            snap_ff <= pins_sync;
    end

    a_snap_refresh: assert property (@(posedge ref_clk) disable iff (!nrst)
        port_access |=> snap_ff == $past(pins_sync))
        else $error("snapshot not refreshed on port access");
    a_snap_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !port_access |=> $stable(snap_ff))
        else $error("snapshot moved without port access");
endmodule

// [verification/pin_board.sv]
`timescale 1ns/1ps
module pin_board
(
    input  wire logic       ref_clk,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe_n,
    input  wire logic [5:0] pullup_on,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_level,
    output logic      [5:0] pin_in
);
    logic [5:0] float_ff = 6'h00;
    // an undriven line wanders each cycle so a stale level never passes
    always_ff @(posedge ref_clk)
        float_ff <= ~pin_in;
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_level[i];
            else if (pullup_on[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_ff[i];
        end
    end
endmodule

// [verification/gpio_port_tb.sv]
`timescale 1ns/1ps
module gpio_port_tb;
    import gpio_pkg::*;
    logic       ref_clk, nrst, wr_stb, rd_stb;
    logic [7:0] addr, wdata, rdata;
    logic [5:0] pin_in, pin_out, pin_oe_n, pullup_on, ext_en, ext_level;
    logic [1:0] adc01, cmp01;
    logic       irq, wake_up, cmp_out, t0, ext_irq, vref, adc2;
    int         mismatches, total_checks, cycles;

    gpio_port i_dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_on(pullup_on), .comparator_digital_output(cmp_out),
        .timer_zero_clock_input(t0), .ext_edge_irq(ext_irq),
        .adc_sel_pin01(adc01), .cmp_sel_pin01(cmp01), .adc_vref_sel(vref),
        .adc_sel_pin2(adc2), .wake_up(wake_up), .irq(irq));
    pin_board i_board (.ref_clk(ref_clk), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .ext_en(ext_en),
        .ext_level(ext_level), .pin_in(pin_in));

    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] m, logic [7:0] e, string nm);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        chk(nm, e, rdata & m);
    endtask
    task automatic hold(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic reset_values();
        rd(PIN_DIRECTION_ADDR, 8'hff, 8'h3f, "dir");
        rd(PULLUP_ENABLE_ADDR, 8'hff, 8'h37, "pu");
        rd(CHANGE_IRQ_ADDR, 8'hff, 8'h00, "ioc");
        chk("pullup_on", 8'h00, {2'b00, pullup_on});
    endtask
    task automatic register_masks();
        wr(PIN_DIRECTION_ADDR, 8'h00);
        rd(PIN_DIRECTION_ADDR, 8'hff, 8'h08, "dir");
        chk("oe_n", 8'h08, {2'b00, pin_oe_n});
        wr(CHANGE_IRQ_ADDR, 8'hff);
        rd(CHANGE_IRQ_ADDR, 8'hff, 8'h3f, "ioc");
        wr(CHANGE_IRQ_ADDR, 8'h00);
        wr(PULLUP_ENABLE_ADDR, 8'hff);
        rd(PULLUP_ENABLE_ADDR, 8'hff, 8'h37, "pu");
        rd(8'h40, 8'hff, 8'h00, "unmapped");
    endtask
    task automatic port_data();
        ext_en <= 6'h08;
        ext_level <= 6'h08;
        wr(PORT_DATA_ADDR, 8'h2a);
        hold(4);
        chk("pin_out", 8'h22, {2'b00, pin_out & 6'h37});
        rd(PORT_DATA_ADDR, 8'hff, 8'h2a, "port");
    endtask
    task automatic pullups();
        wr(PIN_DIRECTION_ADDR, 8'h3f);
        wr(OPTION_ADDR, 8'h00);
        hold(2);
        chk("pullup_on", 8'h37, {2'b00, pullup_on});
        wr(PULLUP_ENABLE_ADDR, 8'h05);
        wr(PIN_DIRECTION_ADDR, 8'h3e);
        hold(2);
        chk("pullup_on", 8'h04, {2'b00, pullup_on});
        wr(OPTION_ADDR, 8'h80);
        hold(2);
        chk("pullup_on", 8'h00, {2'b00, pullup_on});
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 20 && irq !== 1'b1; i++)
            hold(1);
    endtask
    task automatic change_irq();
        wr(PIN_DIRECTION_ADDR, 8'h3f);
        ext_en <= 6'h3f;
        ext_level <= 6'h00;
        wr(EVT_ENABLE_ADDR, 8'h01);
        wr(CHANGE_IRQ_ADDR, 8'h01);
        wr(IRQ_CTRL_ADDR, 8'h80);
        hold(3);
        rd(PORT_DATA_ADDR, 8'hff, 8'h00, "refresh");
        chk("irq", 8'h00, {7'h0, irq});
        ext_level <= 6'h01;
        wait_irq();
        chk("irq", 8'h01, {7'h0, irq});
        chk("wake", 8'h01, {7'h0, wake_up});
        wr(IRQ_CTRL_ADDR, 8'h80);
        hold(3);
        rd(IRQ_CTRL_ADDR, 8'h81, 8'h81, "flag held");
        rd(EVT_STATUS_ADDR, 8'h03, 8'h01, "status");
        rd(PORT_DATA_ADDR, 8'hff, 8'h01, "refresh");
        wr(IRQ_CTRL_ADDR, 8'h80);
        wr(EVT_CLEAR_ADDR, 8'h01);
        hold(2);
        rd(IRQ_CTRL_ADDR, 8'h81, 8'h80, "flag clear");
        chk("irq", 8'h00, {7'h0, irq});
        wr(IRQ_CTRL_ADDR, 8'h00);
        ext_level <= 6'h00;
        hold(6);
        rd(IRQ_CTRL_ADDR, 8'h81, 8'h01, "flag no gie");
        chk("irq", 8'h00, {7'h0, irq});
        rd(PORT_DATA_ADDR, 8'hff, 8'h00, "refresh");
        wr(IRQ_CTRL_ADDR, 8'h00);
        ext_level <= 6'h02;
        hold(6);
        rd(IRQ_CTRL_ADDR, 8'h81, 8'h00, "masked pin");
        wr(PIN_FUNC_ADDR, 8'h05);
        hold(2);
        chk("adc sel", 8'h03, {6'h0, adc01});
    endtask
    task automatic pin_functions();
        int n;
        wr(PIN_FUNC_ADDR, 8'h0e);
        hold(2);
        chk("cmp sel", 8'h01, {6'h0, cmp01});
        chk("vref sel", 8'h01, {7'h0, vref});
        chk("adc sel", 8'h00, {6'h0, adc01});
        ext_level <= 6'h04;
        wr(PIN_FUNC_ADDR, 8'h10);
        hold(2);
        chk("adc2 sel", 8'h01, {7'h0, adc2});
        rd(PORT_DATA_ADDR, 8'hff, 8'h00, "analog pin");
        wr(PIN_FUNC_ADDR, 8'h20);
        hold(2);
        chk("timer clk", 8'h01, {7'h0, t0});
        ext_level <= 6'h00;
        hold(3);
        chk("timer clk", 8'h00, {7'h0, t0});
        wr(PIN_FUNC_ADDR, 8'h30);
        wr(EVT_ENABLE_ADDR, 8'h02);
        wr(EVT_CLEAR_ADDR, 8'h03);
        wr(IRQ_CTRL_ADDR, 8'h80);
        hold(2);
        chk("irq", 8'h00, {7'h0, irq});
        ext_level <= 6'h04;
        n = 0;
        repeat (8)
        begin
            hold(1);
            if (ext_irq === 1'b1)
                n++;
        end
        chk("edge pulses", 8'h01, n[7:0]);
        chk("irq", 8'h01, {7'h0, irq});
        rd(EVT_STATUS_ADDR, 8'h02, 8'h02, "status");
        wr(EVT_CLEAR_ADDR, 8'h02);
        hold(2);
        chk("irq", 8'h00, {7'h0, irq});
        cmp_out <= 1'b1;
        wr(PIN_FUNC_ADDR, 8'h40);
        hold(3);
        chk("cmp out", 8'h02, {6'h0, pin_out[2], pin_oe_n[2]});
        cmp_out <= 1'b0;
        hold(3);
        chk("cmp out", 8'h00, {6'h0, pin_out[2], pin_oe_n[2]});
    endtask
    task automatic mid_reset();
        nrst <= 1'b0;
        hold(2);
        chk("oe_n", 8'h3f, {2'b00, pin_oe_n});
        nrst <= 1'b1;
        reset_values();
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial
    begin
        cycles = 0;
        forever
        begin
            @(posedge ref_clk);
            cycles++;
            if (cycles == 5000)
            begin
                mismatches++;
                final_report();
            end
        end
    end
    initial
    begin
        nrst = 1'b0;
        {addr, wdata, wr_stb, rd_stb} = '0;
        ext_en = 6'h08;
        ext_level = 6'h00;
        cmp_out = 1'b0;
        mismatches = 0;
        total_checks = 0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        reset_values();
        register_masks();
        port_data();
        pullups();
        change_irq();
        pin_functions();
        mid_reset();
        final_report();
    end
endmodule
